// ===== hdl/bus_command_generator.sv
`timescale 1ns/1ps
`include "bus_cmd_consts.svh"
// Behaviour
// (RL1) 000 ack, 001 io read, 010 io write plus early io write, 110 mem write both.
// (RL2) 011 and 111 give nothing; 100 and 101 give memory read.
// (RL3) processor holds status all high when no bus cycle runs.
// (RL4) every output is timed from the core clock.
// (RL5) address strobe active high; latches capture on its falling edge.
// (RL6) transceiver enable active high during transfers.
// (RL7) direction high for writes, low for reads.
// (RL8) commands enabled no sooner than 85 ns after bus grant goes low.
// (RL9) bus grant going inactive releases command drivers at once.
// (RL10) in io-bus mode bus grant does not affect io commands.
// (RL11) qualifier low forces commands and data enables inactive.
// (RL12) strap high selects io-bus mode, low selects system-bus mode.
// (RL13) early io write is active low with read timing.
// (RL14) early memory write is active low with read timing.
// (RL15) memory and io read and write commands are active low.
// (RL16) interrupt acknowledge is active low.
// (RL17) strap low: dual pin is active-high cascade enable in ack cycles.
// (RL18) strap high: dual pin is active-low peripheral data enable.
// (RL19) io-bus mode: io commands and ack always enabled.
// (RL20) io-bus mode: io command starts at once with peripheral enable.
// (RL21) io-bus mode: memory commands still wait for bus grant.
// (RL22) system-bus mode: all commands wait for bus grant.
// (RL23) arbiter drives bus grant low only when the bus is free.
// (RL24) io commands must not drive the system bus in io-bus mode.
// (RL25) qualifier low holds commands driven inactive, not released.
// (RL26) address strobe pulses every machine cycle, latching status.
// (RL27) outside logic masks cascade enable in the first ack cycle.
// (RL28) cycle starts when status leaves passive, ends on return to it.
module bus_command_generator
    import bus_cmd_pkg::*;
#(
    parameter int GRANT_CYC = `GRANT_DELAY_CYC
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // processor side
    input wire logic [2:0] cpu_status_lines,
    // arbitration and qualifiers
    input wire logic bus_grant_n,
    input wire logic cmd_qualifier,
    input wire logic io_bus_strap,
    // command outputs, oe low while driving
    output logic mem_rd_n,
    output logic mem_wr_n,
    output logic early_mem_wr_n,
    output logic io_rd_n,
    output logic io_wr_n,
    output logic early_io_wr_n,
    output logic irq_ack_n,
    output logic mem_cmd_oe_n,
    output logic io_cmd_oe_n,
    // control outputs
    output logic addr_strobe,
    output logic xcvr_enable,
    output logic xfer_direction,
    output logic cascade_or_periph_en
);
    logic [2:0] stat_s;
    logic grant_n_s;
    logic qual_s;
    logic strap_s;
    cycle_state_t state_reg;
    logic [2:0] code_reg;
    logic [`GRANT_CNT_W-1:0] grant_cnt_reg;
    logic granted;
    logic io_mode;
    cmd_kind_t kind;
    logic is_write;
    logic kind_ok;
    logic active;
    logic late;
    logic new_cycle;
    logic stat_write;
    logic want_mem_rd;
    logic want_mem_wr;
    logic want_early_mem_wr;
    logic want_io_rd;
    logic want_io_wr;
    logic want_early_io_wr;
    logic want_irq_ack;

    sync2 #(.WIDTH(3), .INIT(3'h7)) u_sync_stat (
        .core_clk(core_clk), .resetn(resetn), .d(cpu_status_lines), .q(stat_s));
    sync2 #(.WIDTH(3), .INIT(3'h5)) u_sync_ctl (
        .core_clk(core_clk), .resetn(resetn),
        .d({bus_grant_n, cmd_qualifier, io_bus_strap}),
        .q({grant_n_s, qual_s, strap_s}));

    assign io_mode = strap_s; // RL12

    // decode of latched status
    always_comb begin
        kind = K_NONE;
        is_write = 1'b0;
        case (code_reg)
            `STAT_IRQ_ACK: kind = K_ACK; // RL1
            `STAT_IO_RD: kind = K_IO; // RL1
            `STAT_IO_WR: begin
                kind = K_IO; // RL1
                is_write = 1'b1;
            end
            `STAT_CODE, `STAT_MEM_RD: kind = K_MEM; // RL2
            `STAT_MEM_WR: begin
                kind = K_MEM; // RL1
                is_write = 1'b1;
            end
            default: kind = K_NONE; // RL2
        endcase
    end

    // grant settle counter, held clear while synced grant is high, counts once it goes low
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            grant_cnt_reg <= '0;
        end else if (grant_n_s) begin
            grant_cnt_reg <= '0; // RL9
        end else if (grant_cnt_reg < GRANT_CYC[`GRANT_CNT_W-1:0]) begin
            grant_cnt_reg <= grant_cnt_reg + 1'b1; // RL8
        end
    end
    assign granted = !grant_n_s && (grant_cnt_reg >= GRANT_CYC[`GRANT_CNT_W-1:0]); // RL8

    // io and ack bypass grant in io-bus mode, memory never does
    always_comb begin
        kind_ok = granted; // RL22
        if (io_mode && (kind == K_IO || kind == K_ACK)) begin
            kind_ok = 1'b1; // RL10 RL19 RL20
        end else if (kind == K_MEM) begin
            kind_ok = granted; // RL21
        end
    end

    // machine cycle sequencer
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (new_cycle) begin
                        state_reg <= ST_ADDR; // RL28
                    end
                end
                ST_ADDR: begin
                    state_reg <= ST_CMD;
                end
                ST_CMD: begin
                    state_reg <= ST_HOLD;
                end
                ST_HOLD: begin
                    if (stat_s == `STAT_PASSIVE) begin
                        state_reg <= ST_IDLE; // RL28
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // status latched with the address strobe
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            code_reg <= `STAT_PASSIVE;
        end else if (new_cycle) begin
            code_reg <= stat_s; // RL26
        end else if (state_reg == ST_HOLD && stat_s == `STAT_PASSIVE) begin
            code_reg <= `STAT_PASSIVE; // RL28
        end
    end

    assign new_cycle = (state_reg == ST_IDLE) && (stat_s != `STAT_PASSIVE); // RL28
    assign stat_write = (stat_s == `STAT_IO_WR) || (stat_s == `STAT_MEM_WR); // RL7
    assign active = (state_reg == ST_CMD || state_reg == ST_HOLD) && stat_s != `STAT_PASSIVE
        && qual_s && kind_ok; // RL11 RL28
    assign late = active && state_reg == ST_HOLD;

    // per-command requests from the latched code
    assign want_mem_rd = active && kind == K_MEM && !is_write; // RL2
    assign want_early_mem_wr = active && kind == K_MEM && is_write; // RL14
    assign want_mem_wr = late && kind == K_MEM && is_write; // RL1
    assign want_io_rd = active && kind == K_IO && !is_write; // RL1
    assign want_early_io_wr = active && kind == K_IO && is_write; // RL13
    assign want_io_wr = late && kind == K_IO && is_write; // RL1
    assign want_irq_ack = active && kind == K_ACK; // RL16

    // address strobe one pulse per cycle
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            addr_strobe <= 1'b0;
        end else begin
            addr_strobe <= new_cycle; // RL5 RL26
        end
    end

    // command strobes, driven inactive when qualifier is low
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            mem_rd_n <= 1'b1;
        end else begin
            mem_rd_n <= !want_mem_rd; // RL15 RL4
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            early_mem_wr_n <= 1'b1;
        end else begin
            early_mem_wr_n <= !want_early_mem_wr; // RL14
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            mem_wr_n <= 1'b1;
        end else begin
            mem_wr_n <= !want_mem_wr; // RL15
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            io_rd_n <= 1'b1;
        end else begin
            io_rd_n <= !want_io_rd; // RL15
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            early_io_wr_n <= 1'b1;
        end else begin
            early_io_wr_n <= !want_early_io_wr; // RL13
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            io_wr_n <= 1'b1;
        end else begin
            io_wr_n <= !want_io_wr; // RL15
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            irq_ack_n <= 1'b1;
        end else begin
            irq_ack_n <= !want_irq_ack; // RL16
        end
    end

    // driver enables: released without grant except io in io-bus mode, kept on under qualifier low
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            mem_cmd_oe_n <= 1'b1;
        end else begin
            mem_cmd_oe_n <= !granted; // RL9 RL25
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            io_cmd_oe_n <= 1'b1;
        end else begin
            io_cmd_oe_n <= !(granted || io_mode); // RL10 RL19 RL25
        end
    end

    // transceiver enable, memory only in io-bus mode
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            xcvr_enable <= 1'b0;
        end else begin
            xcvr_enable <= active && (kind == K_MEM || (!io_mode && kind != K_NONE)); // RL6 RL11
        end
    end

    // direction set with the strobe so the latch phase already sees it
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            xfer_direction <= 1'b0;
        end else if (state_reg == ST_IDLE) begin
            xfer_direction <= new_cycle && stat_write; // RL7
        end else begin
            xfer_direction <= is_write; // RL7
        end
    end

    // dual pin: cascade pulse or peripheral enable
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cascade_or_periph_en <= 1'b0;
        end else if (io_mode) begin
            cascade_or_periph_en <= !(active && (kind == K_IO || kind == K_ACK)); // RL18 RL20
        end else begin
            cascade_or_periph_en <= new_cycle && (stat_s == `STAT_IRQ_ACK); // RL17
        end
    end
endmodule : bus_command_generator

// ===== hdl/bus_cmd_consts.svh
`ifndef BUS_CMD_CONSTS_SVH
`define BUS_CMD_CONSTS_SVH

// status codes on cpu_status_lines, bit 2 is the first printed line
`define STAT_IRQ_ACK 3'h0
`define STAT_IO_RD 3'h1
`define STAT_IO_WR 3'h2
`define STAT_HALT 3'h3
`define STAT_CODE 3'h4
`define STAT_MEM_RD 3'h5
`define STAT_MEM_WR 3'h6
`define STAT_PASSIVE 3'h7

// grant settle time and clock period
`define GRANT_DELAY_NS 85
`define CLK_PERIOD_NS 10
`define GRANT_DELAY_CYC ((`GRANT_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define GRANT_CNT_W 4

`endif

// ===== hdl/bus_cmd_pkg.sv
package bus_cmd_pkg;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_ADDR = 4'h2,
        ST_CMD = 4'h4,
        ST_HOLD = 4'h8
    } cycle_state_t;

    typedef enum logic [2:0] {
        K_NONE = 3'h0,
        K_IO = 3'h1,
        K_MEM = 3'h2,
        K_ACK = 3'h3
    } cmd_kind_t;

endpackage : bus_cmd_pkg

// ===== hdl/sync2.sv
`timescale 1ns/1ps
// two-flop synchroniser for pin inputs
module sync2 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            meta_reg <= INIT;
            q <= INIT;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule : sync2

// ===== verification/bus_cmd_chk.sv
`timescale 1ns/1ps
module bus_cmd_chk
    import bus_cmd_pkg::*;
#(
    parameter int GRANT_CYC = 9
) (
    // clock and reset
    input wire logic core_clk, resetn,
    // inputs
    input wire logic bus_grant_n, cmd_qualifier, io_bus_strap,
    // outputs
    input wire logic mem_rd_n, mem_wr_n, early_mem_wr_n, io_rd_n, io_wr_n, early_io_wr_n,
    input wire logic irq_ack_n, mem_cmd_oe_n, io_cmd_oe_n, addr_strobe
);
    logic [4:0] gcnt_reg;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            gcnt_reg <= 5'h00;
        end else if (bus_grant_n) begin
            gcnt_reg <= 5'h00;
        end else if (gcnt_reg != 5'h1f) begin
            gcnt_reg <= gcnt_reg + 5'h01;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    property p_pulse; addr_strobe |=> !addr_strobe; endproperty
    a_pulse: assert property (p_pulse) else $error("strobe too long");
    property p_mem_early; !mem_wr_n |-> !early_mem_wr_n; endproperty
    a_mem_early: assert property (p_mem_early) else $error("mem early write");
    property p_io_early; !io_wr_n |-> !early_io_wr_n; endproperty
    a_io_early: assert property (p_io_early) else $error("io early write");
    property p_qual;
        !cmd_qualifier [*4] |-> &{mem_rd_n, mem_wr_n, early_mem_wr_n, io_rd_n, io_wr_n, irq_ack_n};
    endproperty
    a_qual: assert property (p_qual) else $error("qualifier low");
    property p_one; !mem_rd_n |-> mem_wr_n && io_rd_n && io_wr_n && irq_ack_n; endproperty
    a_one: assert property (p_one) else $error("two commands");
    property p_delay; $fell(mem_cmd_oe_n) |-> gcnt_reg >= GRANT_CYC; endproperty
    a_delay: assert property (p_delay) else $error("enable too early");
    property p_release; bus_grant_n [*5] |-> mem_cmd_oe_n; endproperty
    a_release: assert property (p_release) else $error("mem not released");
    property p_sys_io; (bus_grant_n && !io_bus_strap) [*5] |-> io_cmd_oe_n; endproperty
    a_sys_io: assert property (p_sys_io) else $error("io not released");
endmodule : bus_cmd_chk
bind bus_command_generator bus_cmd_chk #(.GRANT_CYC(GRANT_CYC)) u_chk (
    .core_clk(core_clk), .resetn(resetn), .bus_grant_n(bus_grant_n),
    .cmd_qualifier(cmd_qualifier), .io_bus_strap(io_bus_strap), .mem_rd_n(mem_rd_n),
    .mem_wr_n(mem_wr_n), .early_mem_wr_n(early_mem_wr_n), .io_rd_n(io_rd_n),
    .io_wr_n(io_wr_n), .early_io_wr_n(early_io_wr_n), .irq_ack_n(irq_ack_n),
    .mem_cmd_oe_n(mem_cmd_oe_n), .io_cmd_oe_n(io_cmd_oe_n), .addr_strobe(addr_strobe));

// ===== verification/cpu_bus_model.sv
`timescale 1ns/1ps
module cpu_bus_model (
    // clock
    input wire logic core_clk,
    // bench requests
    input wire logic go, want_bus,
    input wire logic [2:0] code,
    // pins
    output logic [2:0] cpu_status_lines,
    output logic bus_grant_n
);
    int left = 0;
    initial begin
        cpu_status_lines = 3'h7;
        bus_grant_n = 1'b1;
    end
    always @(negedge core_clk) begin
        bus_grant_n <= !want_bus;
        if (go) begin
            cpu_status_lines <= code;
            left = 20;
        end else if (left > 0) begin
            left = left - 1;
            if (left == 0) cpu_status_lines <= 3'h7;
        end
    end
endmodule : cpu_bus_model

// ===== verification/bus_command_generator_tb.sv
`timescale 1ns/1ps
module bus_command_generator_tb;
    import bus_cmd_pkg::*;
    logic core_clk = 1'b0, resetn = 1'b0, go = 1'b0, want = 1'b0;
    logic io_bus_strap = 1'b0, cmd_qualifier = 1'b1, dir_seen = 1'b0;
    logic xcvr_seen = 1'b0, dual_seen = 1'b0;
    logic [2:0] code = 3'h7, cpu_status_lines;
    logic bus_grant_n, mem_rd_n, mem_wr_n, early_mem_wr_n, io_rd_n, io_wr_n, early_io_wr_n;
    logic irq_ack_n, mem_cmd_oe_n, io_cmd_oe_n, addr_strobe, xcvr_enable, xfer_direction;
    logic cascade_or_periph_en;
    logic [6:0] act = 7'h00;
    int pulses = 0, failures = 0, tests_run = 0, cycles = 0, seed = 32'h118c, r;
    always #5 core_clk = ~core_clk;
    cpu_bus_model partner (.core_clk(core_clk), .go(go), .want_bus(want), .code(code),
        .cpu_status_lines(cpu_status_lines), .bus_grant_n(bus_grant_n));
    bus_command_generator DUT (
        .core_clk(core_clk), .resetn(resetn), .cpu_status_lines(cpu_status_lines),
        .bus_grant_n(bus_grant_n), .cmd_qualifier(cmd_qualifier), .io_bus_strap(io_bus_strap),
        .mem_rd_n(mem_rd_n), .mem_wr_n(mem_wr_n), .early_mem_wr_n(early_mem_wr_n),
        .io_rd_n(io_rd_n), .io_wr_n(io_wr_n), .early_io_wr_n(early_io_wr_n),
        .irq_ack_n(irq_ack_n), .mem_cmd_oe_n(mem_cmd_oe_n), .io_cmd_oe_n(io_cmd_oe_n),
        .addr_strobe(addr_strobe), .xcvr_enable(xcvr_enable), .xfer_direction(xfer_direction),
        .cascade_or_periph_en(cascade_or_periph_en));
    task give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : give_verdict
    task check(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    always @(posedge core_clk) begin
        cycles++;
        act |= ~{mem_rd_n | mem_cmd_oe_n, mem_wr_n | mem_cmd_oe_n, early_mem_wr_n | mem_cmd_oe_n,
            io_rd_n | io_cmd_oe_n, io_wr_n | io_cmd_oe_n, early_io_wr_n | io_cmd_oe_n,
            irq_ack_n | io_cmd_oe_n};
        xcvr_seen |= xcvr_enable === 1'b1;
        dual_seen |= cascade_or_periph_en !== io_bus_strap;
        if (addr_strobe === 1'b1) begin
            pulses++;
            dir_seen = xfer_direction;
        end
        if (cycles == 6000) begin
            failures++;
            give_verdict();
        end
    end
    function logic [6:0] exp_cmd(input logic [2:0] c, input logic s, q, w);
        logic m, i;
        m = q & w;
        i = q & (w | s);
        case (c)
            3'h0: exp_cmd = {6'h00, i};
            3'h1: exp_cmd = {3'h0, i, 3'h0};
            3'h2: exp_cmd = {4'h0, i, i, 1'b0};
            3'h4, 3'h5: exp_cmd = {m, 6'h00};
            3'h6: exp_cmd = {1'b0, m, m, 4'h0};
            default: exp_cmd = 7'h00;
        endcase
    endfunction : exp_cmd
    function logic exp_xcvr(input logic [2:0] c, input logic s, q, w);
        logic [6:0] e;
        e = exp_cmd(c, s, q, w);
        exp_xcvr = s ? |e[6:4] : |e;
    endfunction : exp_xcvr
    function logic exp_dual(input logic [2:0] c, input logic s, q);
        exp_dual = s ? (q && c <= 3'h2) : (c == 3'h0);
    endfunction : exp_dual
    task run(input logic [2:0] c, input logic s, q, w);
        @(negedge core_clk);
        io_bus_strap <= s;
        cmd_qualifier <= q;
        want <= w;
        repeat (6) @(negedge core_clk);
        act = 7'h00;
        pulses = 0;
        dir_seen = 1'b0;
        xcvr_seen = 1'b0;
        dual_seen = 1'b0;
        go <= 1'b1;
        code <= c;
        @(negedge core_clk);
        go <= 1'b0;
        repeat (30) @(negedge core_clk);
        check("commands", {1'b0, exp_cmd(c, s, q, w)}, {1'b0, act});
        check("strobes", (c == 3'h7) ? 8'h00 : 8'h01, pulses[7:0]);
        check("direction", {7'h00, c == 3'h2 || c == 3'h6}, {7'h00, dir_seen});
        check("xcvr_enable", {7'h00, exp_xcvr(c, s, q, w)}, {7'h00, xcvr_seen});
        check("dual_pin", {7'h00, exp_dual(c, s, q)}, {7'h00, dual_seen});
    endtask : run
    initial begin
        repeat (6) @(negedge core_clk);
        resetn <= 1'b1;
        for (int i = 0; i < 16; i++) run(i[2:0], i[3], 1'b1, ~i[3]);
        for (int i = 0; i < 40; i++) begin
            r = $random(seed);
            run(r[2:0], r[3], r[5:4] != 2'b00, r[6]);
        end
        give_verdict();
    end
endmodule : bus_command_generator_tb
